// file: src/asorc_cfg.svh
// constants for the serial output mode and reset control block
`ifndef ASORC_CFG_SVH
`define ASORC_CFG_SVH
`define ASORC_ADDR_POWER_MODE 13'h0008
`define ASORC_ADDR_SERIAL_OUT 13'h0021
`define ASORC_ADDR_USER_IO3 13'h0102
`define ASORC_RST_SERIAL_OUT 8'h32
`define ASORC_MASK_POWER_MODE 8'h23
`define ASORC_MASK_USER_IO3 8'h08
`define ASORC_PM_FIELD 1:0
`define ASORC_PM_RESET 2'h3
`define ASORC_VCM_BIT 3
`define ASORC_SO_NARROW_BIT 0
`define ASORC_SO_DOUBLE_FRAME_BIT 2
`define ASORC_LANE_FIELD 7:4
`define ASORC_LANE_DDR_BYTE 4'h3
`define ASORC_LANE_DDR_BIT 4'h2
`define ASORC_LANE_SDR_BYTE 4'h1
`define ASORC_LANE_SDR_BIT 4'h0
`define ASORC_LANE_DDR_ONE 4'h4
`define ASORC_LAST_ONE_12 4'hB
`define ASORC_LAST_ONE_10 4'h9
`define ASORC_LAST_TWO_12 4'h5
`define ASORC_LAST_TWO_10 4'h4
`define ASORC_WORD_MSB 11
`define ASORC_HALF_12 6
`define ASORC_HALF_10 5
`define ASORC_RECOVER_CYCLES 2900000
`define ASORC_SPI_READ_BIT 15
`define ASORC_SPI_INSTR_LAST 5'h0F
`define ASORC_SPI_DATA_LAST 5'h17
`define ASORC_SPI_DONE 5'h18
`define ASORC_CHANNELS 4
`define ASORC_SAMPLE_BITS 12
`define ASORC_FIFO_DEPTH 16
`endif

// file: src/asorc_pkg.sv
// types shared by the serial output mode and reset control block
package asorc_pkg;
  typedef enum logic [2:0] {
    DP_RESET = 3'h1,
    DP_RECOVER = 3'h2,
    DP_RUN = 3'h4
  } asorc_dp_state_type;

  typedef struct packed {
    logic [7:0] mode;
    logic [3:0][11:0] data;
  } asorc_word_type;

  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] sclkSync;
    logic [1:0] sdiSync;
    logic sclkLast;
    logic [4:0] bitCount;
    logic [23:0] shiftIn;
    logic isRead;
    logic [7:0] readShift;
    logic spiDataOut;
    logic spiDataOe;
    logic [7:0] powerMode;
    logic [7:0] serialCtl;
    logic [7:0] userIo3;
    logic vcmPowerDown;
    asorc_dp_state_type dpState;
    logic [21:0] recCount;
    logic conversionReady;
    logic dpHold;
    logic pending;
    asorc_word_type word;
  } asorc_main_type;

  typedef struct packed {
    logic [1:0] holdSync;
    logic active;
    asorc_word_type word;
    logic [3:0] bitIdx;
    logic [3:0] lastIdx;
    logic halfStep;
    logic firstOfPair;
    logic [7:0] laneOut;
    logic frameOut;
    logic bitClkOut;
  } asorc_link_type;
endpackage

// file: src/asorc_fifo.sv
// dual clock word fifo with gray coded pointers
`timescale 1ns/1ps
module asorc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic wrClock, // filling side clock
  input wire logic wrRst_n, // filling side reset
  input wire logic wrValid, // word offered
  output logic wrReady, // room for a word
  input wire logic [WIDTH-1:0] wrData, // offered word
  input wire logic rdClock, // draining side clock
  input wire logic rdRst_n, // draining side reset
  output logic rdValid, // word available
  input wire logic rdReady, // drain takes word
  output logic [WIDTH-1:0] rdData // head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] sync1;
    logic [AW:0] sync2;
  } asorc_fifo_side_type;

  logic [WIDTH-1:0] mem [DEPTH];
  asorc_fifo_side_type w, next_w, r, next_r;
  logic push, pop;

  always_comb begin
    next_w = w;
    next_r = r;
    wrReady = w.gray != {~w.sync2[AW:AW-1], w.sync2[AW-2:0]};
    rdValid = r.gray != r.sync2;
    push = wrValid && wrReady;
    pop = rdValid && rdReady;
    next_w.bin = w.bin + (AW+1)'(push);
    next_w.gray = next_w.bin ^ (next_w.bin >> 1);
    next_w.sync1 = r.gray;
    next_w.sync2 = w.sync1;
    next_r.bin = r.bin + (AW+1)'(pop);
    next_r.gray = next_r.bin ^ (next_r.bin >> 1);
    next_r.sync1 = w.gray;
    next_r.sync2 = r.sync1;
  end

  assign rdData = mem[r.bin[AW-1:0]];

  always_ff @(posedge wrClock) begin
    if (push) begin
      mem[w.bin[AW-1:0]] <= wrData;
    end
  end

  always_ff @(posedge wrClock or negedge wrRst_n) begin
    if (!wrRst_n) begin
      w <= '0;
    end else begin
      w <= next_w;
    end
  end

  always_ff @(posedge rdClock or negedge rdRst_n) begin
    if (!rdRst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// file: src/asorc_control.sv
// serial output mode, power mode and digital reset control of a quad adc
`timescale 1ns/1ps
`include "asorc_cfg.svh"
module asorc_control import asorc_pkg::*; #(
  parameter int unsigned RECOVER_CYCLES = `ASORC_RECOVER_CYCLES
) (
  input wire logic clock, // sample clock
  input wire logic rst_n, // power-on reset
  input wire logic lineClock, // serial line clock
  input wire logic portSelect_n, // serial port select pin
  input wire logic spiClock, // serial port clock pin
  input wire logic spiDataIn, // serial data pin level
  output logic spiDataOut, // serial data pin drive value
  output logic spiDataOe, // serial data pin drive enable
  input wire logic [3:0][11:0] sampleData, // converter core samples
  output logic vcmPowerDown, // common-mode generator off
  output logic conversionReady, // normal conversion running
  output logic [7:0] laneOut, // data lanes, two per channel
  output logic frameOut, // frame clock
  output logic bitClkOut // bit_rate_clock_out
);
  asorc_main_type s, next_s;
  asorc_link_type l, next_l;
  logic [1:0] lineRstSync;
  logic lineRst_n;
  logic wrStrobe;
  logic [12:0] wrAddr;
  logic [7:0] wrData;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  asorc_word_type fifoOutData;
  logic [7:0] laneBits;
  logic lineHold;
  logic lineStep;
  logic lineDouble;

  localparam asorc_main_type MAIN_RESET = '{
    csSync: '1, // select sync starts at the pin's idle level
    serialCtl: `ASORC_RST_SERIAL_OUT,
    dpState: DP_RECOVER,
    default: '0
  };

  function automatic logic [7:0] readReg(asorc_main_type st, logic [12:0] addr);
    if (addr == `ASORC_ADDR_POWER_MODE) begin
      readReg = st.powerMode;
    end else if (addr == `ASORC_ADDR_SERIAL_OUT) begin
      readReg = st.serialCtl;
    end else if (addr == `ASORC_ADDR_USER_IO3) begin
      readReg = st.userIo3;
    end else begin
      readReg = 8'h00;
    end
  endfunction

  function automatic logic isDdr(logic [7:0] mode);
    logic [3:0] lane;
    lane = mode[`ASORC_LANE_FIELD];
    isDdr = lane == `ASORC_LANE_DDR_BYTE || lane == `ASORC_LANE_DDR_BIT || lane == `ASORC_LANE_DDR_ONE;
  endfunction

  function automatic logic [3:0] lastBitIndex(logic [7:0] mode);
    logic narrow;
    narrow = mode[`ASORC_SO_NARROW_BIT];
    if (mode[`ASORC_LANE_FIELD] == `ASORC_LANE_DDR_ONE) begin
      lastBitIndex = narrow ? `ASORC_LAST_ONE_10 : `ASORC_LAST_ONE_12;
    end else begin
      lastBitIndex = narrow ? `ASORC_LAST_TWO_10 : `ASORC_LAST_TWO_12;
    end
  endfunction

  function automatic logic laneBit(logic [11:0] w, logic [7:0] mode, logic [3:0] idx, logic second);
    logic [3:0] lane;
    int pos;
    lane = mode[`ASORC_LANE_FIELD];
    pos = 0;
    if (lane == `ASORC_LANE_DDR_ONE) begin
      pos = second ? -1 : `ASORC_WORD_MSB - int'(idx);
    end else if (lane == `ASORC_LANE_DDR_BIT || lane == `ASORC_LANE_SDR_BIT) begin
      pos = `ASORC_WORD_MSB - int'(second) - 2 * int'(idx);
    end else begin
      pos = `ASORC_WORD_MSB - int'(idx);
      if (second) begin
        pos = pos - (mode[`ASORC_SO_NARROW_BIT] ? `ASORC_HALF_10 : `ASORC_HALF_12);
      end
    end
    if (pos < 0) begin
      laneBit = 1'b0;
    end else begin
      laneBit = w[pos[3:0]];
    end
  endfunction

  // sample clock domain: serial port, registers, datapath state
  always_comb begin
    logic csActive;
    logic sclkRise;
    logic sclkFall;
    next_s = s;
    csActive = 1'b0;
    sclkRise = 1'b0;
    sclkFall = 1'b0;
    wrStrobe = 1'b0;
    wrAddr = s.shiftIn[20:8];
    wrData = s.shiftIn[7:0];
    next_s.csSync = {s.csSync[0], portSelect_n};
    next_s.sclkSync = {s.sclkSync[0], spiClock};
    next_s.sdiSync = {s.sdiSync[0], spiDataIn};
    next_s.sclkLast = s.sclkSync[1];
    csActive = !s.csSync[1];
    sclkRise = s.sclkSync[1] && !s.sclkLast;
    sclkFall = !s.sclkSync[1] && s.sclkLast;
    if (!csActive) begin
      next_s.bitCount = 5'h00;
      next_s.isRead = 1'b0;
      next_s.spiDataOe = 1'b0;
      next_s.spiDataOut = 1'b0;
    end else begin
      if (sclkRise && s.bitCount != `ASORC_SPI_DONE) begin
        next_s.shiftIn = {s.shiftIn[22:0], s.sdiSync[1]};
        next_s.bitCount = s.bitCount + 5'h01;
        if (s.bitCount == `ASORC_SPI_INSTR_LAST && next_s.shiftIn[`ASORC_SPI_READ_BIT]) begin
          next_s.isRead = 1'b1;
          next_s.readShift = readReg(s, next_s.shiftIn[12:0]);
        end
        if (s.bitCount == `ASORC_SPI_DATA_LAST && !s.isRead) begin
          wrStrobe = 1'b1;
          wrAddr = next_s.shiftIn[20:8];
          wrData = next_s.shiftIn[7:0];
        end
      end
      if (sclkFall && s.isRead) begin
        next_s.spiDataOe = 1'b1;
        next_s.spiDataOut = s.readShift[7];
        next_s.readShift = {s.readShift[6:0], 1'b0};
      end
    end
    if (wrStrobe) begin
      if (wrAddr == `ASORC_ADDR_POWER_MODE) begin
        next_s.powerMode = wrData & `ASORC_MASK_POWER_MODE;
      end else if (wrAddr == `ASORC_ADDR_SERIAL_OUT) begin
        next_s.serialCtl = wrData;
      end else if (wrAddr == `ASORC_ADDR_USER_IO3) begin
        next_s.userIo3 = wrData & `ASORC_MASK_USER_IO3;
      end
    end
    next_s.vcmPowerDown = next_s.userIo3[`ASORC_VCM_BIT];
    case (s.dpState)
      DP_RESET: begin
        if (s.powerMode[`ASORC_PM_FIELD] != `ASORC_PM_RESET) begin
          next_s.dpState = DP_RECOVER;
          next_s.recCount = 22'h000000;
        end
      end
      DP_RECOVER: begin
        if (s.powerMode[`ASORC_PM_FIELD] == `ASORC_PM_RESET) begin
          next_s.dpState = DP_RESET;
        end else if (s.recCount == 22'(RECOVER_CYCLES - 1)) begin
          next_s.dpState = DP_RUN;
        end else begin
          next_s.recCount = s.recCount + 22'h000001;
        end
      end
      DP_RUN: begin
        if (s.powerMode[`ASORC_PM_FIELD] == `ASORC_PM_RESET) begin
          next_s.dpState = DP_RESET;
        end
      end
      default: begin
        next_s.dpState = DP_RESET;
      end
    endcase
    next_s.conversionReady = next_s.dpState == DP_RUN;
    next_s.dpHold = next_s.dpState == DP_RESET;
    if (s.pending && fifoInReady) begin
      next_s.pending = 1'b0;
    end
    if (s.dpState == DP_RESET) begin
      next_s.pending = 1'b0;
    end else if (!next_s.pending) begin
      next_s.pending = 1'b1;
      next_s.word.mode = s.serialCtl;
      next_s.word.data = s.dpState == DP_RUN ? sampleData : '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= MAIN_RESET;
    end else begin
      s <= next_s;
    end
  end

  asorc_fifo #(
    .WIDTH($bits(asorc_word_type)),
    .DEPTH(`ASORC_FIFO_DEPTH)
  ) wordFifo (
    .wrClock(clock),
    .wrRst_n(rst_n),
    .wrValid(s.pending),
    .wrReady(fifoInReady),
    .wrData(s.word),
    .rdClock(lineClock),
    .rdRst_n(lineRst_n),
    .rdValid(fifoOutValid),
    .rdReady(fifoOutReady),
    .rdData(fifoOutData)
  );

  // line clock domain: reset release, serializer
  always_ff @(posedge lineClock or negedge rst_n) begin
    if (!rst_n) begin
      lineRstSync <= 2'h0;
    end else begin
      lineRstSync <= {lineRstSync[0], 1'b1};
    end
  end
  assign lineRst_n = lineRstSync[1];

  for (genvar ch = 0; ch < `ASORC_CHANNELS; ch++) begin : gLane
    assign laneBits[2*ch] = l.active && laneBit(l.word.data[ch], l.word.mode, l.bitIdx, 1'b0);
    assign laneBits[2*ch+1] = l.active && laneBit(l.word.data[ch], l.word.mode, l.bitIdx, 1'b1);
  end

  always_comb begin
    next_l = l;
    next_l.holdSync = {l.holdSync[0], s.dpHold};
    lineHold = l.holdSync[1];
    lineStep = isDdr(l.word.mode) || l.halfStep;
    lineDouble = fifoOutData.mode[`ASORC_SO_DOUBLE_FRAME_BIT];
    // while held, drain and drop stale live words so none leak out after release
    fifoOutReady = lineHold || !l.active || (lineStep && l.bitIdx == l.lastIdx);
    next_l.halfStep = !l.halfStep;
    next_l.bitClkOut = !lineHold && !l.bitClkOut;
    if (l.active && lineStep) begin
      if (l.bitIdx == l.lastIdx) begin
        next_l.active = 1'b0;
      end else begin
        next_l.bitIdx = l.bitIdx + 4'h1;
      end
    end
    if (fifoOutValid && fifoOutReady) begin
      next_l.active = 1'b1;
      next_l.word = fifoOutData;
      next_l.bitIdx = 4'h0;
      next_l.halfStep = 1'b0;
      next_l.lastIdx = lastBitIndex(fifoOutData.mode);
      next_l.firstOfPair = !lineDouble || !l.firstOfPair;
    end
    if (lineHold) begin
      next_l.active = 1'b0;
      next_l.firstOfPair = 1'b0;
    end
    next_l.laneOut = laneBits;
    next_l.frameOut = l.active && l.firstOfPair && (l.word.mode[`ASORC_SO_DOUBLE_FRAME_BIT]
      || l.bitIdx < ((l.lastIdx + 4'h1) >> 1));
  end

  always_ff @(posedge lineClock or negedge lineRst_n) begin
    if (!lineRst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign spiDataOut = s.spiDataOut;
  assign spiDataOe = s.spiDataOe;
  assign vcmPowerDown = s.vcmPowerDown;
  assign conversionReady = s.conversionReady;
  assign laneOut = l.laneOut;
  assign frameOut = l.frameOut;
  assign bitClkOut = l.bitClkOut;

  vcm_power_a: assert property (@(posedge clock) disable iff (!rst_n)
    wrStrobe && wrAddr == `ASORC_ADDR_USER_IO3 |=> vcmPowerDown == $past(wrData[`ASORC_VCM_BIT]))
    else $error("common-mode power-down does not follow write");
  write_immediate_a: assert property (@(posedge clock) disable iff (!rst_n)
    wrStrobe && wrAddr == `ASORC_ADDR_SERIAL_OUT |=> s.serialCtl == $past(wrData))
    else $error("serial output control write not immediate");
  reset_enter_a: assert property (@(posedge clock) disable iff (!rst_n)
    s.powerMode[`ASORC_PM_FIELD] == `ASORC_PM_RESET |=> s.dpState == DP_RESET ##1 !s.pending)
    else $error("datapath not held by reset code");
  reset_release_a: assert property (@(posedge clock) disable iff (!rst_n)
    s.dpState == DP_RESET && s.powerMode[`ASORC_PM_FIELD] != `ASORC_PM_RESET
    |=> s.dpState == DP_RECOVER && s.recCount == 22'h000000)
    else $error("recovery not started after reset code cleared");
  recover_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    s.dpState == DP_RECOVER && s.recCount != 22'(RECOVER_CYCLES - 1)
    && s.powerMode[`ASORC_PM_FIELD] != `ASORC_PM_RESET |=> s.dpState == DP_RECOVER)
    else $error("conversion resumed before recovery count");
  ready_flag_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s.dpState == DP_RUN) |-> s.conversionReady && $past(s.recCount) == 22'(RECOVER_CYCLES - 1))
    else $error("ready flag out of step with recovery");
  zero_words_a: assert property (@(posedge clock) disable iff (!rst_n)
    s.pending && $past(s.dpState) != DP_RUN |-> s.word.data == '0)
    else $error("nonzero word during recovery");
  lane_count_a: assert property (@(posedge lineClock) disable iff (!lineRst_n)
    l.active |-> int'(l.lastIdx) + 1 == ((l.word.mode[`ASORC_SO_NARROW_BIT] ? `ASORC_HALF_10 : `ASORC_HALF_12)
    << int'(l.word.mode[`ASORC_LANE_FIELD] == `ASORC_LANE_DDR_ONE)))
    else $error("bits per lane do not match mode");
  frame_align_a: assert property (@(posedge lineClock) disable iff (!lineRst_n)
    $rose(frameOut) |-> $past(l.bitIdx) == 4'h0 || $past(l.bitIdx, 2) == l.lastIdx)
    else $error("frame does not start at first bit");
endmodule

// file: tb/asorc_capture.sv
// far side model capturing channel 0 lanes and frame
`timescale 1ns/1ps
module asorc_capture (
  input wire logic lineClock, // link clock
  input wire logic rst_n, // reset
  input wire logic [1:0] laneIn, // channel 0 lanes
  input wire logic frameIn, // frame clock
  input wire logic [3:0] bitsPerLane, // bits per lane per word
  output logic [11:0] word0, // last first-lane word
  output logic [11:0] word1, // last second-lane word
  output logic [3:0] frameLen, // last frame high run
  output logic [15:0] wordCount // words captured
);
  logic frameLast;
  logic [3:0] bitCount;
  logic [3:0] highCount;
  logic [11:0] sh0;
  logic [11:0] sh1;
  always_ff @(posedge lineClock or negedge rst_n) begin
    if (!rst_n) begin
      {frameLast, bitCount, highCount, sh0, sh1} <= '0;
      {word0, word1, frameLen, wordCount} <= '0;
    end else begin
      frameLast <= frameIn;
      if (frameIn && !frameLast) begin
        sh0 <= {11'h000, laneIn[0]};
        sh1 <= {11'h000, laneIn[1]};
        bitCount <= 4'h1;
        highCount <= 4'h1;
      end else begin
        if (frameIn) highCount <= highCount + 4'h1;
        if (!frameIn && frameLast) frameLen <= highCount;
        if (bitCount != 4'h0) begin
          sh0 <= {sh0[10:0], laneIn[0]};
          sh1 <= {sh1[10:0], laneIn[1]};
          bitCount <= bitCount + 4'h1;
          if (bitCount + 4'h1 == bitsPerLane) begin
            word0 <= {sh0[10:0], laneIn[0]};
            word1 <= {sh1[10:0], laneIn[1]};
            wordCount <= wordCount + 16'h0001;
            bitCount <= 4'h0;
          end
        end
      end
    end
  end
endmodule

// file: tb/asorc_control_tb.sv
// self-checking bench for the serial output mode and reset control block
`timescale 1ns/1ps
module asorc_control_tb;
  import asorc_pkg::*;
  localparam int REC = 200;
  logic clock = 1'b0;
  logic lineClock = 1'b0;
  logic rst_n = 1'b0;
  logic portSelect_n = 1'b1;
  logic spiClock = 1'b0;
  logic hostBit = 1'b0;
  logic hostOe = 1'b0;
  logic [3:0][11:0] sampleData = {12'h3C1, 12'h2B7, 12'h196, 12'hA5C};
  logic spiDataOut;
  logic spiDataOe;
  logic vcmPowerDown;
  logic conversionReady;
  logic frameOut;
  logic bitClkOut;
  logic [7:0] laneOut;
  logic [3:0] bitsPerLane = 4'h6;
  logic [11:0] word0;
  logic [11:0] word1;
  logic [3:0] frameLen;
  logic [15:0] wordCount;
  int num_errors = 0;
  int checked = 0;
  // pull-down on the shared data pin when nobody drives
  wire logic sdio = spiDataOe ? spiDataOut : (hostOe ? hostBit : 1'b0);

  initial forever #25 clock = ~clock;
  initial begin
    #3.7;
    forever #7.5 lineClock = ~lineClock;
  end

  asorc_control #(.RECOVER_CYCLES(REC)) i_asorc_control (.clock(clock), .rst_n(rst_n),
    .lineClock(lineClock), .portSelect_n(portSelect_n), .spiClock(spiClock), .spiDataIn(sdio),
    .spiDataOut(spiDataOut), .spiDataOe(spiDataOe), .sampleData(sampleData),
    .vcmPowerDown(vcmPowerDown), .conversionReady(conversionReady), .laneOut(laneOut),
    .frameOut(frameOut), .bitClkOut(bitClkOut));

  asorc_capture i_asorc_capture (.lineClock(lineClock), .rst_n(rst_n), .laneIn(laneOut[1:0]),
    .frameIn(frameOut), .bitsPerLane(bitsPerLane), .word0(word0), .word1(word1),
    .frameLen(frameLen), .wordCount(wordCount));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask

  // 24-bit frame, data changed while the serial clock is low
  task automatic spi_xfer(input logic [23:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clock);
    portSelect_n <= 1'b0;
    repeat (5) @(posedge clock);
    for (int i = 23; i >= 0; i--) begin
      spiClock <= 1'b0;
      hostBit <= frame[i];
      hostOe <= !(frame[23] && i < 8);
      repeat (5) @(posedge clock);
      if (i < 8) rd[i] = sdio;
      spiClock <= 1'b1;
      repeat (5) @(posedge clock);
    end
    spiClock <= 1'b0;
    hostOe <= 1'b0;
    portSelect_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] junk;
    spi_xfer({3'b000, a, d}, junk);
  endtask

  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] s;
    spi_xfer({3'b100, a, 8'h00}, s);
    chk($sformatf("register %h", a), {8'h00, e}, {8'h00, s});
  endtask

  task automatic wait_ready(output int n);
    n = 0;
    while (conversionReady !== 1'b1) begin
      @(negedge clock);
      n++;
      if (n > REC + 100) begin
        chk("conversionReady", 16'h1, 16'h0);
        final_report();
      end
    end
  endtask

  task automatic t_power_on();
    int n;
    wait_ready(n);
    chk("initial recovery", 16'h1, {15'h0, n >= REC - 5 && n <= REC + 10});
    rd(13'h0021, 8'h32);
    rd(13'h0008, 8'h00);
    rd(13'h0102, 8'h00);
    rd(13'h0055, 8'h00);
    chk("vcmPowerDown", 16'h0, {15'h0, vcmPowerDown});
  endtask

  task automatic t_common_mode();
    wr(13'h0102, 8'hFF);
    chk("vcmPowerDown", 16'h1, {15'h0, vcmPowerDown});
    rd(13'h0102, 8'h08);
    wr(13'h0102, 8'h00);
    chk("vcmPowerDown", 16'h0, {15'h0, vcmPowerDown});
  endtask

  task automatic t_digital_reset();
    int n;
    int bad;
    wr(13'h0008, 8'hFF);
    @(negedge clock);
    chk("conversionReady", 16'h0, {15'h0, conversionReady});
    chk("lanes in reset", 16'h0, {7'h00, bitClkOut, laneOut});
    rd(13'h0008, 8'h23);
    wr(13'h0008, 8'h00);
    n = 0;
    bad = 0;
    while (conversionReady !== 1'b1 && n < REC + 100) begin
      @(negedge clock);
      n++;
      if (n > 0 && conversionReady !== 1'b1 && laneOut !== 8'h00) bad++;
    end
    chk("recovery window", 16'h1, {15'h0, n >= REC - 15 && n <= REC + 2});
    chk("zero words", 16'h0, bad[15:0]);
    // reset code cleared by the very next instruction
    wr(13'h0008, 8'h03);
    wr(13'h0008, 8'h00);
    chk("conversionReady", 16'h0, {15'h0, conversionReady});
    wait_ready(n);
    chk("second recovery", 16'h1, {15'h0, n >= REC - 15 && n <= REC + 2});
  endtask

  task automatic mode_case(input logic [7:0] code, input logic [3:0] n, input logic [3:0] fl,
                           input logic [11:0] e0, input logic [11:0] e1);
    logic [15:0] start;
    int k;
    logic b;
    wr(13'h0021, code);
    bitsPerLane <= n;
    start = wordCount;
    k = 0;
    while (wordCount - start < 16'd24) begin
      @(negedge clock);
      k++;
      if (k > 2000) begin
        chk("captured words", 16'd24, wordCount - start);
        final_report();
      end
    end
    rd(13'h0021, code);
    chk($sformatf("first lane %h", code), {4'h0, e0}, {4'h0, word0});
    chk($sformatf("second lane %h", code), {4'h0, e1}, {4'h0, word1});
    chk($sformatf("frame run %h", code), {12'h000, fl}, {12'h000, frameLen});
    @(posedge lineClock);
    b = bitClkOut;
    @(posedge lineClock);
    chk("bitClkOut toggle", {15'h0, !b}, {15'h0, bitClkOut});
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    t_power_on();
    t_common_mode();
    t_digital_reset();
    mode_case(8'h32, 4'h6, 4'h3, 12'h029, 12'h01C);
    mode_case(8'h22, 4'h6, 4'h3, 12'h032, 12'h00E);
    // sdr (8'h12): capture at line rate sees every bit twice; 8'h42 is one-lane ddr, each bit once
    mode_case(8'h12, 4'hC, 4'h6, 12'hCC3, 12'h3F0);
    mode_case(8'h42, 4'hC, 4'h6, 12'hA5C, 12'h000);
    mode_case(8'h33, 4'h5, 4'h2, 12'h014, 12'h017);
    mode_case(8'h23, 4'h5, 4'h2, 12'h019, 12'h007);
    mode_case(8'h36, 4'h6, 4'h6, 12'h029, 12'h01C);
    final_report();
  end
endmodule
